//--- cgl_regs.vh
// Register map and field constants for the coulomb gauge latch block
`ifndef CGL_REGS_VH
`define CGL_REGS_VH
`define CGL_ADDR_W          8
`define CGL_OFS_CONFIG      8'h18
`define CGL_OFS_COMMAND     8'h19
`define CGL_OFS_DIS_LOW     8'h1a
`define CGL_OFS_DIS_HIGH    8'h1b
`define CGL_OFS_CHG_LOW     8'h1c
`define CGL_OFS_CHG_HIGH    8'h1d
`define CGL_BIT_POWER_ON    7
`define CGL_BIT_SHORT       6
`define CGL_SEL_HI          5
`define CGL_SEL_LO          4
`define CGL_BIT_DIR         3
`define CGL_BIT_SNAPSHOT    7
`define CGL_BIT_CLR_DIS     6
`define CGL_BIT_CLR_CHG     5
`define CGL_SEL_CMD         2'b00
`define CGL_SEL_ADC         2'b01
`define CGL_SEL_GTIMER      2'b10
`define CGL_SEL_STIMER      2'b11
`define CGL_BYTE_ZERO       8'h00
`define CGL_CNT_ZERO        16'h0000
`define CGL_CNT_ONE         16'h0001
`define CGL_CNT_MAX         16'hffff
`endif

//--- cgl_latch_regs.v
// Coulomb gauge control, counters and snapshot registers
`timescale 1ns/10ps
`include "cgl_regs.vh"
// Overview of operation
// R01 - Power-on bit enables the counting block
// R02 - Calibration bit shorts the sense inputs
// R03 - Latch source field, 00 gives command control
// R04 - Code 01 latches at conversion start, end
// R05 - Code 10 latches on general timer overflow
// R06 - Code 11 latches on slow timer overflow
// R07 - Read-only flag shows current direction
// R08 - Snapshot command copies both counters
// R09 - Command bit clears discharge counter
// R10 - Command bit clears charge counter
// R11 - Commands act only with source 00
// R12 - Discharge snapshot readable as two bytes
// R13 - Charge snapshot readable as two bytes
// R14 - Two 16-bit counters, increment only
// R15 - Overflow wraps to zero, raises request
// R16 - Latch samples only settled counter values
// R17 - All snapshot bytes update together
module cgl_latch_regs (
   input  wire        clk_sys_i,
   input  wire        srst_i,
   input  wire [7:0]  reg_addr_i,
   input  wire        reg_wr_i,
   input  wire        reg_rd_i,
   input  wire [7:0]  reg_wdata_i,
   output reg  [7:0]  reg_rdata_o,
   input  wire        charge_pulse_i,
   input  wire        discharge_pulse_i,
   input  wire        charge_dir_i,
   input  wire        adc_conv_start_i,
   input  wire        adc_conv_done_i,
   input  wire        general_timer_ovf_i,
   input  wire        slow_tick_timer_ovf_i,
   output wire        gauge_power_on_o,
   output wire        sense_input_short_o,
   output wire [1:0]  latch_source_sel_o,
   output reg         charge_ovf_o,
   output reg         discharge_ovf_o
);

   reg         power_on_q;
   reg         short_q;
   reg  [1:0]  sel_q;
   reg  [15:0] chg_cnt_q;
   reg  [15:0] dis_cnt_q;
   reg  [15:0] chg_latch_q;
   reg  [15:0] dis_latch_q;
   reg  [7:0]  rdata_d;
   reg         latch_ev;

   wire wr_cfg = reg_wr_i && (reg_addr_i == `CGL_OFS_CONFIG);
   wire wr_cmd = reg_wr_i && (reg_addr_i == `CGL_OFS_COMMAND)
                 && (sel_q == `CGL_SEL_CMD); // R11
   wire clr_dis = wr_cmd && reg_wdata_i[`CGL_BIT_CLR_DIS]; // R09
   wire clr_chg = wr_cmd && reg_wdata_i[`CGL_BIT_CLR_CHG]; // R10
   wire chg_inc = power_on_q && !short_q && charge_pulse_i; // R01 R02
   wire dis_inc = power_on_q && !short_q && discharge_pulse_i; // R01 R02

   assign gauge_power_on_o    = power_on_q;
   assign sense_input_short_o = short_q;
   assign latch_source_sel_o  = sel_q;

   // Latch event select
   always @* begin
      case (sel_q)
         `CGL_SEL_CMD:    latch_ev = wr_cmd && reg_wdata_i[`CGL_BIT_SNAPSHOT]; // R03 R08
         `CGL_SEL_ADC:    latch_ev = adc_conv_start_i || adc_conv_done_i; // R04
         `CGL_SEL_GTIMER: latch_ev = general_timer_ovf_i; // R05
         default:         latch_ev = slow_tick_timer_ovf_i; // R06
      endcase
   end

   // Configuration register
   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         power_on_q <= 1'b0;
         short_q    <= 1'b0;
         sel_q      <= `CGL_SEL_CMD;
      end else if (wr_cfg) begin
         power_on_q <= reg_wdata_i[`CGL_BIT_POWER_ON]; // R01
         short_q    <= reg_wdata_i[`CGL_BIT_SHORT]; // R02
         sel_q      <= reg_wdata_i[`CGL_SEL_HI:`CGL_SEL_LO]; // R03
      end
   end

   // Live counters, clear wins over increment
   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         chg_cnt_q    <= `CGL_CNT_ZERO;
         dis_cnt_q    <= `CGL_CNT_ZERO;
         charge_ovf_o <= 1'b0;
         discharge_ovf_o <= 1'b0;
      end else begin
         charge_ovf_o    <= chg_inc && !clr_chg && (chg_cnt_q == `CGL_CNT_MAX); // R15
         discharge_ovf_o <= dis_inc && !clr_dis && (dis_cnt_q == `CGL_CNT_MAX); // R15
         if (clr_chg)
            chg_cnt_q <= `CGL_CNT_ZERO; // R10
         else if (chg_inc)
            chg_cnt_q <= chg_cnt_q + `CGL_CNT_ONE; // R14 R15
         if (clr_dis)
            dis_cnt_q <= `CGL_CNT_ZERO; // R09
         else if (dis_inc)
            dis_cnt_q <= dis_cnt_q + `CGL_CNT_ONE; // R14 R15
      end
   end

   // Snapshot from registered counters, never mid-update
   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         chg_latch_q <= `CGL_CNT_ZERO; // R13
         dis_latch_q <= `CGL_CNT_ZERO; // R12
      end else if (latch_ev) begin
         chg_latch_q <= chg_cnt_q; // R16 R17
         dis_latch_q <= dis_cnt_q; // R16 R17
      end
   end

   // Read decode
   always @* begin
      rdata_d = `CGL_BYTE_ZERO;
      if (reg_addr_i == `CGL_OFS_CONFIG) begin
         rdata_d[`CGL_BIT_POWER_ON] = power_on_q;
         rdata_d[`CGL_BIT_SHORT] = short_q;
         rdata_d[`CGL_SEL_HI:`CGL_SEL_LO] = sel_q;
         rdata_d[`CGL_BIT_DIR] = charge_dir_i; // R07
      end else if (reg_addr_i == `CGL_OFS_DIS_LOW)
         rdata_d = dis_latch_q[7:0]; // R12
      else if (reg_addr_i == `CGL_OFS_DIS_HIGH)
         rdata_d = dis_latch_q[15:8]; // R12
      else if (reg_addr_i == `CGL_OFS_CHG_LOW)
         rdata_d = chg_latch_q[7:0]; // R13
      else if (reg_addr_i == `CGL_OFS_CHG_HIGH)
         rdata_d = chg_latch_q[15:8]; // R13
   end

   always @(posedge clk_sys_i) begin
      if (srst_i)
         reg_rdata_o <= `CGL_BYTE_ZERO;
      else if (reg_rd_i)
         reg_rdata_o <= rdata_d;
   end

endmodule

//--- cgl_sense_model.sv
// Sense front end model
`timescale 1ns/10ps
module cgl_sense_model(
   input  logic clk_sys_i, run_i, dir_i,
   output logic cp_o, dp_o);
   always @(posedge clk_sys_i) {cp_o, dp_o} <= {run_i & dir_i, run_i & ~dir_i};
endmodule

//--- cgl_latch_asserts.sv
// Gauge checker
`timescale 1ns/10ps
module cgl_latch_asserts(
   input logic clk_sys_i, srst_i, reg_wr_i, reg_rd_i, charge_dir_i, charge_ovf_o,
   input logic gauge_power_on_o, sense_input_short_o,
   input logic [1:0] latch_source_sel_o,
   input logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);
   wire w = reg_wr_i && reg_addr_i == 8'h18;
   wire r = reg_rd_i && reg_addr_i == 8'h18;
   AST_PWR:
   assert property (w |=> gauge_power_on_o == $past(reg_wdata_i[7])) else $error("pw");
   AST_SHRT:
   assert property (w |=> sense_input_short_o == $past(reg_wdata_i[6])) else $error("sh");
   AST_SELW:
   assert property (w |=> latch_source_sel_o == $past(reg_wdata_i[5:4])) else $error("sw");
   AST_SELH:
   assert property (!w |=> $stable(latch_source_sel_o)) else $error("sk");
   AST_DIR:
   assert property (r |=> reg_rdata_o[3:0] == {$past(charge_dir_i), 3'h0}) else $error("d");
   AST_WO:
   assert property (reg_rd_i && reg_addr_i == 8'h19 |=> reg_rdata_o == 8'h00) else $error("wo");
   AST_HOLD:
   assert property (!reg_rd_i |=> $stable(reg_rdata_o)) else $error("h");
   AST_OVF:
   assert property (charge_ovf_o |=> !charge_ovf_o) else $error("o");
   cover property (w ##1 latch_source_sel_o == 2'h3);
   cover property (reg_wr_i && reg_addr_i == 8'h19);
   cover property (r);
endmodule
bind cgl_latch_regs cgl_latch_asserts chk(.*);

//--- cgl_latch_regs_bench.sv
// Gauge register block testbench
`timescale 1ns/10ps
module cgl_latch_regs_bench;
   logic clk_sys_i = 0, srst_i = 1, reg_rd_i = 0, reg_wr_i = 0, charge_dir_i = 1, run = 0;
   logic charge_pulse_i, discharge_pulse_i;
   logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
   logic [3:0] ev = 4'h0;
   logic [31:0] e = 32'h0000_0000;
   int err_total = 0, check_count = 0, cyc = 0;
   initial forever #10 clk_sys_i = ~clk_sys_i;
   cgl_sense_model sm(.clk_sys_i, .run_i(run), .dir_i(charge_dir_i), .cp_o(charge_pulse_i),
      .dp_o(discharge_pulse_i));
   cgl_latch_regs dut(.*, .adc_conv_start_i(ev[0]), .adc_conv_done_i(ev[1]),
      .general_timer_ovf_i(ev[2]), .slow_tick_timer_ovf_i(ev[3]), .gauge_power_on_o(),
      .sense_input_short_o(), .latch_source_sel_o(), .charge_ovf_o(), .discharge_ovf_o());
   always @(posedge clk_sys_i) if (++cyc > 2000) begin err_total++; stop_test; end
   task automatic acc(input logic [7:0] ad, d, logic w);
      @(posedge clk_sys_i) begin
         {reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i} <= {ad, d, w, !w};
      end
      @(posedge clk_sys_i) {reg_wr_i, reg_rd_i} <= 2'h0;
      #1 if (!w) begin
         check_count++;
         if (reg_rdata_o !== d) begin err_total++; $display("wrong value %0t %h", $time, ad); end
      end
   endtask
   task automatic pulse(input int n, logic d);
      @(posedge clk_sys_i) {run, charge_dir_i} <= {1'h1, d};
      repeat (n) @(posedge clk_sys_i);
      run <= 0;
      repeat (2) @(posedge clk_sys_i);
      e += d ? n << 16 : n;
   endtask
   task automatic snap;
      for (int i = 0; i < 4; i++) acc(8'h1a + 8'(i), 8'(e >> 8 * i), 0);
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk_sys_i);
      srst_i <= 0;
      snap;
      acc(8'h18, 8'h08, 0);
      acc(8'h18, 8'h80, 1);
      pulse(20, 1);
      pulse(9, 0);
      acc(8'h19, 8'h80, 1);
      snap;
      acc(8'h19, 8'h60, 1);
      e = 0;
      pulse(5, 1);
      acc(8'h19, 8'h80, 1);
      snap;
      for (int i = 0; i < 4; i++) begin
         acc(8'h18, 8'h80 | 8'(i ? i : 1) << 4, 1);
         pulse(3 + i, i[0]);
         acc(8'h19, 8'h60, 1);
         @(posedge clk_sys_i) ev <= 4'h1 << i;
         @(posedge clk_sys_i) ev <= 4'h0;
         snap;
      end
      acc(8'h18, 8'hc0, 1);
      acc(8'h18, 8'hc8, 0);
      pulse(4, 1);
      e -= 32'h0004_0000;
      acc(8'h19, 8'h80, 1);
      snap;
      stop_test;
   end
endmodule
